//--- pkg/btbc_pkg.sv
package btbc_pkg;

	// ****************************************
	// Quarter-cycle timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int Q_DIV = 2;
	localparam logic [3:0] Q_DIV_LAST = 4'(Q_DIV - 1);
	localparam logic [1:0] Q1_IDX = 2'h0;
	localparam logic [1:0] Q2_IDX = 2'h1;
	localparam logic [1:0] Q3_IDX = 2'h2;
	localparam logic [1:0] Q4_IDX = 2'h3;

	// ****************************************
	// Opcodes and fields
	// ****************************************
	localparam logic [3:0] OP_TOGGLE = 4'h7;
	localparam logic [7:0] OP_BR_OVF = 8'hE4;
	localparam logic [7:0] OP_BR_ZERO = 8'hE0;
	localparam logic [6:0] OP_CALL = 7'h76;
	localparam logic [3:0] OP_SECOND = 4'hF;
	localparam int BIT_SEL_LSB = 9;
	localparam int BANK_MODE_BIT = 8;
	localparam int SAVE_BIT = 8;
	localparam logic [7:0] IDX_MAX = 8'h5F;
	localparam logic [7:0] ACC_SPLIT = 8'h60;
	localparam logic [3:0] ACC_HI_BANK = 4'hF;
	localparam logic [3:0] ACC_LO_BANK = 4'h0;
	localparam logic [20:0] PC_STEP = 21'h00_0002;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_BANK = 8'h04;
	localparam logic [7:0] REG_PC = 8'h08;
	localparam logic [7:0] REG_SHADOW = 8'h0C;
	localparam logic [7:0] REG_STATE = 8'h10;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_EXT_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [7:0] BSR_RST = 8'h00;
	localparam logic [20:0] PC_RST = 21'h00_0000;

	typedef enum logic {MODE_EXEC, MODE_IDLE} btbc_mode_e;

endpackage : btbc_pkg

//--- logic/btbc_qgen.sv
`timescale 1ns/1ps
module btbc_qgen
	import btbc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// Control
	input wire logic run_in,
	// Quarter phase
	output logic tick_out,
	output logic [1:0] quarter_out
);

	typedef struct packed {
		logic [3:0] div;
		logic [1:0] q;
	} btbc_qgen_s;

	btbc_qgen_s q_reg;
	btbc_qgen_s q_next;

	always_comb begin
		q_next = q_reg;
		tick_out = run_in && (q_reg.div == Q_DIV_LAST);
		if (!run_in) begin
			// Restart at the first quarter
			q_next = '0;
		end else if (tick_out) begin
			q_next.div = 4'h0;
			q_next.q = q_reg.q + 2'h1;
		end else begin
			q_next.div = q_reg.div + 4'h1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign quarter_out = q_reg.q;

endmodule : btbc_qgen

//--- logic/btbc_exec.sv
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
module btbc_exec
	import btbc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// APB slave
	input wire logic [7:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Program memory
	output logic [20:0] pmem_addr_out,
	input wire logic [15:0] pmem_data_in,
	// Data memory
	output logic [11:0] dmem_addr_out,
	output logic dmem_rd_out,
	input wire logic [7:0] dmem_rdata_in,
	output logic dmem_we_out,
	output logic [7:0] dmem_wdata_out,
	// Core state
	input wire logic [7:0] w_in,
	input wire logic [7:0] status_in,
	input wire logic ovf_flag_in,
	input wire logic zero_flag_in,
	input wire logic [11:0] fsr2_in,
	// Return stack
	output logic stack_push_out,
	output logic [20:0] stack_data_out
);

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic is_toggle(input logic [15:0] ir);
		return ir[15:12] == OP_TOGGLE;
	endfunction : is_toggle

	function automatic logic is_branch(input logic [15:0] ir);
		return (ir[15:8] == OP_BR_OVF) || (ir[15:8] == OP_BR_ZERO);
	endfunction : is_branch

	function automatic logic is_call(input logic [15:0] ir);
		return ir[15:9] == OP_CALL;
	endfunction : is_call

	function automatic logic branch_cond(input logic [15:0] ir, input logic ovf, input logic zero);
		return (ir[15:8] == OP_BR_OVF) ? ovf : zero;
	endfunction : branch_cond

	function automatic logic [20:0] branch_off(input logic [15:0] ir);
		return {{12{ir[7]}}, ir[7:0], 1'b0};
	endfunction : branch_off

	function automatic logic [7:0] bit_mask(input logic [15:0] ir);
		return 8'h01 << ir[BIT_SEL_LSB +: 3];
	endfunction : bit_mask

	function automatic logic [11:0] data_addr(input logic [7:0] f, input logic a, input logic ext,
			input logic [7:0] bank_select_reg, input logic [11:0] fsr2);
		if (a) begin
			return {bank_select_reg[3:0], f};
		end else if (ext && (f <= IDX_MAX)) begin
			return fsr2 + {4'h0, f};
		end else if (f < ACC_SPLIT) begin
			return {ACC_LO_BANK, f};
		end else begin
			return {ACC_HI_BANK, f};
		end
	endfunction : data_addr

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [20:0] pc;
		logic [15:0] ir;
		logic [7:0] rd_data;
		logic [7:0] data;
		logic [20:0] target;
		logic taken;
		btbc_mode_e mode;
		logic [7:0] ws;
		logic [7:0] ss;
		logic [7:0] bs;
		logic [7:0] bank_select_reg;
		logic run;
		logic ext;
		logic [31:0] prdata;
		logic pslverr;
		logic [11:0] daddr;
		logic drd;
		logic dwe;
		logic [7:0] dwdata;
		logic push;
		logic [20:0] sdata;
	} btbc_state_s;

	btbc_state_s r_reg;
	btbc_state_s r_next;
	logic tick;
	logic [1:0] quarter;
	logic ex;
	logic apb_setup;
	logic apb_wr;
	logic mapped;

	btbc_qgen u_qgen (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.run_in(r_reg.run),
		.tick_out(tick),
		.quarter_out(quarter)
	);

	assign ex = tick && (r_reg.mode == MODE_EXEC);
	assign apb_setup = psel_in && !penable_in;
	assign apb_wr = psel_in && penable_in && pwrite_in;
	assign mapped = (paddr_in == REG_CTRL) || (paddr_in == REG_BANK) || (paddr_in == REG_PC) ||
		(paddr_in == REG_SHADOW) || (paddr_in == REG_STATE);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		r_next = r_reg;
		r_next.drd = 1'b0;
		r_next.dwe = 1'b0;
		r_next.push = 1'b0;
		if (tick && (r_reg.mode == MODE_IDLE) && (quarter == Q4_IDX)) begin
			// Idle cycle ends; no fetch was made in it
			r_next.mode = MODE_EXEC;
		end
		if (ex) begin
			case (quarter)
				Q1_IDX: begin
					r_next.ir = pmem_data_in;
					r_next.pc = r_reg.pc + PC_STEP;
				end
				Q2_IDX: begin
					if (is_toggle(r_reg.ir)) begin
						r_next.daddr = data_addr(r_reg.ir[7:0], r_reg.ir[BANK_MODE_BIT], r_reg.ext,
							r_reg.bank_select_reg, fsr2_in);
						r_next.drd = 1'b1;
					end
				end
				Q3_IDX: begin
					if (is_toggle(r_reg.ir)) begin
						r_next.rd_data = dmem_rdata_in;
						r_next.data = dmem_rdata_in ^ bit_mask(r_reg.ir);
					end
					if (is_branch(r_reg.ir)) begin
						r_next.taken = branch_cond(r_reg.ir, ovf_flag_in, zero_flag_in);
						r_next.target = r_reg.pc + branch_off(r_reg.ir);
					end
					if (is_call(r_reg.ir)) begin
						r_next.push = 1'b1;
						r_next.sdata = r_reg.pc + PC_STEP;
						if (r_reg.ir[SAVE_BIT]) begin
							r_next.ws = w_in;
							r_next.ss = status_in;
							r_next.bs = r_reg.bank_select_reg;
						end
					end
				end
				Q4_IDX: begin
					if (is_toggle(r_reg.ir)) begin
						r_next.dwe = 1'b1;
						r_next.dwdata = r_reg.data;
					end
					if (is_branch(r_reg.ir) && r_reg.taken) begin
						r_next.pc = r_reg.target;
						r_next.mode = MODE_IDLE;
					end
					if (is_call(r_reg.ir)) begin
						// Second word sits at the current counter
						r_next.pc = {pmem_data_in[11:0], r_reg.ir[7:0], 1'b0};
						r_next.mode = MODE_IDLE;
					end
				end
				default: begin
					r_next.drd = 1'b0;
				end
			endcase
			// Lone second call word and other opcodes fall through untouched
		end
		// Register bus
		if (apb_setup) begin
			r_next.pslverr = !mapped;
			case (paddr_in)
				REG_CTRL: r_next.prdata = {30'h0, r_reg.ext, r_reg.run};
				REG_BANK: r_next.prdata = {24'h00_0000, r_reg.bank_select_reg};
				REG_PC: r_next.prdata = {11'h000, r_reg.pc};
				REG_SHADOW: r_next.prdata = {8'h00, r_reg.bs, r_reg.ss, r_reg.ws};
				REG_STATE: r_next.prdata = {15'h0000, (r_reg.mode == MODE_IDLE), r_reg.ir};
				default: r_next.prdata = 32'h0000_0000;
			endcase
		end
		if (apb_wr) begin
			case (paddr_in)
				REG_CTRL: begin
					r_next.run = pwdata_in[CTRL_RUN_BIT];
					r_next.ext = pwdata_in[CTRL_EXT_BIT];
				end
				REG_BANK: r_next.bank_select_reg = pwdata_in[7:0];
				REG_PC: r_next.pc = {pwdata_in[20:1], 1'b0};
				default: r_next.pslverr = r_reg.pslverr;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r_reg <= '0;
			r_reg.pc <= PC_RST;
			r_reg.bank_select_reg <= BSR_RST;
			r_reg.run <= CTRL_RST[CTRL_RUN_BIT];
			r_reg.ext <= CTRL_RST[CTRL_EXT_BIT];
			r_reg.mode <= MODE_EXEC;
		end else begin
			r_reg <= r_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata_out = r_reg.prdata;
	assign pready_out = 1'b1;
	assign pslverr_out = r_reg.pslverr && psel_in && penable_in;
	assign pmem_addr_out = r_reg.pc;
	assign dmem_addr_out = r_reg.daddr;
	assign dmem_rd_out = r_reg.drd;
	assign dmem_we_out = r_reg.dwe;
	assign dmem_wdata_out = r_reg.dwdata;
	assign stack_push_out = r_reg.push;
	assign stack_data_out = r_reg.sdata;

	// ****************************************
	// Assertions
	// ****************************************
	logic [11:0] pmem_hi;
	logic [23:0] shadows;
	assign pmem_hi = pmem_data_in[11:0];
	assign shadows = {r_reg.ws, r_reg.ss, r_reg.bs};

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!arst_n_in);

	sequence s_toggle_read;
		r_reg.drd && is_toggle(r_reg.ir);
	endsequence

	sequence s_toggle_write;
		r_reg.dwe && (r_reg.dwdata == (r_reg.rd_data ^ bit_mask(r_reg.ir)));
	endsequence

	sequence s_branch_q3;
		ex && (quarter == Q3_IDX) && is_branch(r_reg.ir);
	endsequence

	AST_TOGGLE_WRITE: assert property (s_toggle_read |-> ##4 s_toggle_write)
		else $error("toggle write-back missing or wrong");

	AST_TOGGLE_ONE_BIT: assert property (r_reg.dwe |-> $countones(r_reg.dwdata ^ r_reg.rd_data) == 1)
		else $error("toggle changed other than one bit");

	AST_BANKED_ADDR: assert property ((s_toggle_read and r_reg.ir[BANK_MODE_BIT]) |->
		r_reg.daddr == {r_reg.bank_select_reg[3:0], r_reg.ir[7:0]})
		else $error("banked address wrong");

	AST_INDEXED_ADDR: assert property ((s_toggle_read and (!r_reg.ir[BANK_MODE_BIT] && r_reg.ext &&
		(r_reg.ir[7:0] <= IDX_MAX))) |-> r_reg.daddr == $past(fsr2_in) + {4'h0, r_reg.ir[7:0]})
		else $error("indexed address wrong");

	AST_BRANCH_TAKEN: assert property ((s_branch_q3 and branch_cond(r_reg.ir, ovf_flag_in, zero_flag_in)) |->
		##3 (r_reg.pc == $past(r_reg.pc, 3) + branch_off(r_reg.ir)) && (r_reg.mode == MODE_IDLE))
		else $error("taken branch target wrong");

	AST_BRANCH_NOT_TAKEN: assert property ((s_branch_q3 and
		!branch_cond(r_reg.ir, ovf_flag_in, zero_flag_in)) |->
		##3 (r_reg.pc == $past(r_reg.pc, 3)) && (r_reg.mode == MODE_EXEC))
		else $error("untaken branch changed counter");

	AST_CALL_PUSH: assert property (r_reg.push |-> r_reg.sdata == r_reg.pc + PC_STEP)
		else $error("pushed return address wrong");

	AST_CALL_TARGET: assert property (r_reg.push |->
		##2 r_reg.pc == {$past(pmem_hi), r_reg.ir[7:0], 1'b0})
		else $error("call target wrong");

	AST_SHADOW_SAVE: assert property (r_reg.push && r_reg.ir[SAVE_BIT] |->
		(r_reg.ws == $past(w_in)) && (r_reg.ss == $past(status_in)))
		else $error("shadow save wrong");

	AST_SHADOW_KEEP: assert property (r_reg.push && !r_reg.ir[SAVE_BIT] |-> $stable(shadows))
		else $error("shadows changed without save");

	AST_IDLE_QUIET: assert property (r_reg.mode == MODE_IDLE |-> !r_reg.drd && !r_reg.dwe && !r_reg.push)
		else $error("activity in idle cycle");

	AST_SECOND_WORD_NOP: assert property (ex && (r_reg.ir[15:12] == OP_SECOND) |=>
		!r_reg.drd && !r_reg.dwe && !r_reg.push)
		else $error("lone second word did something");

endmodule : btbc_exec

//--- testbench/btbc_mem_model.sv
`timescale 1ns/1ps
module btbc_mem_model
	import btbc_pkg::*;
(
	// Clock
	input wire logic clk_in,
	// Program memory
	input wire logic [20:0] pmem_addr_in,
	output logic [15:0] pmem_data_out,
	// Data memory
	input wire logic [11:0] dmem_addr_in,
	input wire logic dmem_rd_in,
	output logic [7:0] dmem_rdata_out,
	input wire logic dmem_we_in,
	input wire logic [7:0] dmem_wdata_in,
	// Return stack
	input wire logic stack_push_in,
	input wire logic [20:0] stack_data_in,
	output logic [20:0] tos_out
);
	logic [15:0] prog [0:16383];
	logic [7:0] data [0:4095];
	logic held;

	initial begin
		for (int i = 0; i < 16384; i++) begin
			prog[i] = 16'h0000;
		end
		for (int i = 0; i < 4096; i++) begin
			data[i] = 8'h00;
		end
		dmem_rdata_out = 8'h00;
		tos_out = 21'h00_0000;
		held = 1'b0;
	end

	// Fetch word is combinational, as the core samples it in place
	assign pmem_data_out = prog[pmem_addr_in[14:1]];

	// Read data held from the read until the write, then scrambled
	always @(posedge clk_in) begin
		if (dmem_rd_in) begin
			dmem_rdata_out <= data[dmem_addr_in];
			held <= 1'b1;
		end else if (dmem_we_in || !held) begin
			dmem_rdata_out <= ~dmem_rdata_out;
			held <= 1'b0;
		end
		if (dmem_we_in) begin
			data[dmem_addr_in] <= dmem_wdata_in;
		end
		if (stack_push_in) begin
			tos_out <= stack_data_in;
		end
	end
endmodule : btbc_mem_model

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import btbc_pkg::*;
	logic ref_clk_in, arst_n_in, psel, penable, pwrite, pready, pslverr, err, zf, of;
	logic [7:0] paddr, w, st, rdat;
	logic [31:0] pwdata, prdata, rd;
	logic [20:0] pmem_addr, tgt, tos;
	logic [15:0] pmem_data;
	logic [11:0] daddr;
	logic drd, dwe, push;
	logic [7:0] dwdata;
	logic [20:0] sdata;
	logic [15:0] prog_words [10] = '{16'h7880, 16'h7F22, 16'h7010, 16'hE004, 16'hE401,
		16'h0000, 16'hED34, 16'hF012, 16'hEC45, 16'hF023};
	int error_cnt = 0;
	int n_compared = 0;
	int i;

	btbc_exec DUT (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .paddr_in(paddr), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .pmem_addr_out(pmem_addr), .pmem_data_in(pmem_data),
		.dmem_addr_out(daddr), .dmem_rd_out(drd), .dmem_rdata_in(rdat), .dmem_we_out(dwe),
		.dmem_wdata_out(dwdata), .w_in(w), .status_in(st), .ovf_flag_in(of), .zero_flag_in(zf),
		.fsr2_in(12'h500), .stack_push_out(push), .stack_data_out(sdata));

	btbc_mem_model mm (.clk_in(ref_clk_in), .pmem_addr_in(pmem_addr), .pmem_data_out(pmem_data),
		.dmem_addr_in(daddr), .dmem_rd_in(drd), .dmem_rdata_out(rdat), .dmem_we_in(dwe),
		.dmem_wdata_in(dwdata), .stack_push_in(push), .stack_data_in(sdata), .tos_out(tos));

	// ****************************************
	// Shared tasks
	// ****************************************
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task complete_run;
		if (error_cnt == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_in);
		penable <= 1'b1;
		@(posedge ref_clk_in);
		while (pready !== 1'b1) @(posedge ref_clk_in);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// ****************************************
	// Clock, reset and watchdog
	// ****************************************
	initial begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end

	initial begin
		repeat (6000) @(posedge ref_clk_in);
		error_cnt++;
		complete_run();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		arst_n_in = 1'b0;
		{psel, penable, pwrite, zf, of} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		w = 8'h00;
		st = 8'h00;
		repeat (6) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		for (i = 0; i < 10; i++) begin
			mm.prog[8'h80 + i] = prog_words[i];
		end
		mm.prog[14'h1234] = 16'hF0AB;
		mm.prog[14'h2345] = 16'hF0CD;
		mm.data[12'hF80] = 8'h75;
		apb(1'b0, REG_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b0, REG_BANK, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b0, REG_PC, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b0, 8'h14, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001);
		check(rd, 32'h0000_0000);
		apb(1'b1, REG_BANK, 32'h0000_0003);
		// Pass 0: overflow set, zero clear; pass 1 the reverse with extended set
		for (int p = 0; p < 2; p++) begin
			zf <= p[0];
			of <= !p[0];
			w <= p[0] ? 8'h5A : 8'hA5;
			st <= p[0] ? 8'h03 : 8'h1C;
			apb(1'b1, REG_CTRL, {30'h0, p[0], 1'b0});
			apb(1'b1, REG_PC, 32'h0000_0101);
			apb(1'b0, REG_PC, 32'h0000_0000);
			check(rd, 32'h0000_0100);
			apb(1'b1, REG_CTRL, {30'h0, p[0], 1'b1});
			tgt = p[0] ? 21'h00_468C : 21'h00_246A;
			for (i = 0; i < 400 && pmem_addr !== tgt; i++) @(posedge ref_clk_in);
			check({11'h0, pmem_addr}, {11'h0, tgt});
			apb(1'b1, REG_CTRL, {30'h0, p[0], 1'b0});
			check({24'h0, mm.data[12'hF80]}, p[0] ? 32'h75 : 32'h65);
			check({24'h0, mm.data[12'h322]}, p[0] ? 32'h00 : 32'h80);
			check({24'h0, mm.data[12'h010]}, 32'h01);
			check({24'h0, mm.data[12'h510]}, p[0] ? 32'h01 : 32'h00);
			check({11'h0, tos}, p[0] ? 32'h114 : 32'h110);
			apb(1'b0, REG_SHADOW, 32'h0000_0000);
			check(rd, 32'h0003_1CA5);
			apb(1'b0, REG_STATE, 32'h0000_0000);
			check(rd, p[0] ? 32'h0000_F0CD : 32'h0000_F0AB);
		end
		complete_run();
	end
endmodule : testbench
